// >>> src/spi_fram_defs.vh
// Constants shared by the serial nonvolatile memory command logic.
// Assumes inclusion by bare name from files under src/.
`ifndef SPI_FRAM_DEFS_VH
`define SPI_FRAM_DEFS_VH

// Opcodes
`define SET_WRITE_LATCH_CMD   8'h06
`define CLEAR_WRITE_LATCH_CMD 8'h04
`define STATUS_READ_CMD       8'h05
`define STATUS_WRITE_CMD      8'h01
`define MEM_READ_CMD          8'h03
`define MEM_WRITE_CMD         8'h02

// Status byte layout
`define PIN_GUARD_BIT   7
`define GUARD_HIGH_BIT  3
`define GUARD_LOW_BIT   2
`define LATCH_BIT       1
`define STATUS_RESET    8'h00

// Array geometry
`define ADDR_W          11
`define MEM_DEPTH       2048
`define ADDR_ZERO       11'h000
`define ADDR_ONE        11'h001
`define QUARTER_BASE    11'h600
`define HALF_BASE       11'h400

// Serial framing
`define BIT_LAST        3'h7
`define BIT_ZERO        3'h0
`define BIT_ONE         3'h1

// Write buffer
`define WBUF_W          19
`define WBUF_DEPTH      4
`define WBUF_AW         2

`endif

// >>> src/wbuf_fifo.v
// Small synchronous FIFO for committed write bytes.
// Assumes one clock, synchronous active-high reset, and a clock enable.
`timescale 1ns/10ps
`default_nettype none
module wbuf_fifo #(
	parameter WIDTH = 19,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk,
	input  wire             rst,
	input  wire             ce,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = store[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge clk) begin
		if (rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (push) begin
				store[wr_ptr] <= in_data;
				wr_ptr        <= wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end

endmodule
`default_nettype wire

// >>> src/spi_fram_command_logic.v
// Command, protection and array logic of a 2K x 8 serial nonvolatile memory.
// Assumes SPI pins arrive unsynchronised and are oversampled by SYS_CLK.
//
// How it works
// - First byte decoded as one of six opcodes
// - Write latch clear after power-up
// - Set-latch opcode sets the write latch
// - Status write data never sets latch flag
// - Latch clears at select end after writes
// - Status bits: guard enable, protects, latch
// - Bits 0 and 4-6 read zero
// - Protect and guard bits kept as settings
// - Protect codes select upper quarter, half, all
// - Guard enabled and pin low blocks status writes
// - Pin never affects array writes
// - Status read shifts out status byte
// - Two address bytes, low 11 bits used
// - Burst address increments, wraps to zero
// - Write data MSB first, select ends write
// - Protected address stops burst, discards bytes
// - Each byte committed at its eighth bit
// - Read data MSB first, input ignored
// - Select end stops read, output released
// - Hold low while clock low pauses
// - Unknown opcode ignored until next select
// - Sample on rising, drive on falling
// - Clock level at select picks mode
`timescale 1ns/10ps
`default_nettype none
`include "spi_fram_defs.vh"
module spi_fram_command_logic (
	input  wire SYS_CLK,
	input  wire RST,
	input  wire CE,
	input  wire CS_N,
	input  wire SCK,
	input  wire SI,
	input  wire HOLD_N,
	input  wire WRITE_GUARD_N,
	output reg  SO,
	output reg  SO_OE_N
);

	localparam ST_IDLE   = 3'h0;
	localparam ST_OPCODE = 3'h1;
	localparam ST_ADDR   = 3'h2;
	localparam ST_WDATA  = 3'h3;
	localparam ST_RDATA  = 3'h4;
	localparam ST_SREAD  = 3'h5;
	localparam ST_SWRITE = 3'h6;
	localparam ST_IGNORE = 3'h7;

	// Pin synchronisers
	reg [1:0] cs_sync;
	reg [1:0] sck_sync;
	reg [1:0] si_sync;
	reg [1:0] hold_sync;
	reg [1:0] guard_sync;
	reg       cs_prev;
	reg       sck_prev;

	// Command state
	reg [2:0]         state;
	reg [2:0]         bit_cnt;
	reg [6:0]         rx_shift;
	reg [7:0]         tx_shift;
	reg               addr_hi_done;
	reg               is_read;
	reg [`ADDR_W-1:0] addr;
	reg               burst_stop;
	reg               clear_at_end;
	reg               mode3;
	reg               seen_rise;
	reg               paused;
	reg               so_live;

	// Status register
	reg write_latch_flag;
	reg block_guard_low;
	reg block_guard_high;
	reg pin_guard_enable;

	// Array
	reg [7:0] mem [0:`MEM_DEPTH-1];

	wire cs_s;
	wire sck_s;
	wire si_s;
	wire hold_s;
	wire guard_s;
	wire cs_fall;
	wire cs_rise;
	wire sck_rise;
	wire sck_fall;
	wire [7:0] rx_byte;
	wire       byte_done;
	wire [`ADDR_W-1:0] addr_next;
	wire       fetch;

	// Write buffer handshake
	reg                buf_valid;
	reg  [`WBUF_W-1:0] buf_data;
	wire               buf_ready;
	wire               drain_valid;
	wire               drain_ready;
	wire [`WBUF_W-1:0] drain_data;

	function [7:0] status_byte;
		input guard_en;
		input high;
		input low;
		input latch;
		begin
			status_byte = `STATUS_RESET;
			status_byte[`PIN_GUARD_BIT]  = guard_en;
			status_byte[`GUARD_HIGH_BIT] = high;
			status_byte[`GUARD_LOW_BIT]  = low;
			status_byte[`LATCH_BIT]      = latch;
		end
	endfunction

	function is_protected;
		input             high;
		input             low;
		input [`ADDR_W-1:0] a;
		begin
			case ({high, low})
			2'h0:    is_protected = 1'b0;
			2'h1:    is_protected = (a >= `QUARTER_BASE);
			2'h2:    is_protected = (a >= `HALF_BASE);
			default: is_protected = 1'b1;
			endcase
		end
	endfunction

	assign cs_s     = cs_sync[1];
	assign sck_s    = sck_sync[1];
	assign si_s     = si_sync[1];
	assign hold_s   = hold_sync[1];
	assign guard_s  = guard_sync[1];
	assign cs_fall  = cs_prev & ~cs_s;
	assign cs_rise  = ~cs_prev & cs_s;
	// Edges count only while selected and not paused
	assign sck_rise = ~sck_prev & sck_s & ~cs_s & ~paused & ~cs_fall;
	assign sck_fall = sck_prev & ~sck_s & ~cs_s & ~paused & (~mode3 | seen_rise);
	assign rx_byte  = {rx_shift, si_s};
	assign byte_done = sck_rise & (bit_cnt == `BIT_LAST);
	assign addr_next = addr + `ADDR_ONE;
	// Array read port is shared with the drain; fetch has priority
	assign fetch     = byte_done & ((state == ST_RDATA) |
		((state == ST_ADDR) & addr_hi_done & is_read));
	assign drain_ready = ~fetch;

	always @(posedge SYS_CLK) begin
		if (RST) begin
			cs_sync    <= 2'h3;
			sck_sync   <= 2'h0;
			si_sync    <= 2'h0;
			hold_sync  <= 2'h3;
			guard_sync <= 2'h3;
			cs_prev    <= 1'b1;
			sck_prev   <= 1'b0;
		end else if (CE) begin
			cs_sync    <= {cs_sync[0], CS_N};
			sck_sync   <= {sck_sync[0], SCK};
			si_sync    <= {si_sync[0], SI};
			hold_sync  <= {hold_sync[0], HOLD_N};
			guard_sync <= {guard_sync[0], WRITE_GUARD_N};
			cs_prev    <= cs_s;
			sck_prev   <= sck_s;
		end
	end

	// Hold only changes while the clock is low; deselect clears it at any clock level
	always @(posedge SYS_CLK) begin
		if (RST) begin
			paused <= 1'b0;
		end else if (CE) begin
			if (cs_s)
				paused <= 1'b0;
			else if (~sck_s)
				paused <= ~hold_s;
		end
	end

	// Serial command engine
	always @(posedge SYS_CLK) begin
		if (RST) begin
			state            <= ST_IDLE;
			bit_cnt          <= `BIT_ZERO;
			rx_shift         <= 7'h00;
			tx_shift         <= 8'h00;
			addr_hi_done     <= 1'b0;
			is_read          <= 1'b0;
			addr             <= `ADDR_ZERO;
			burst_stop       <= 1'b0;
			clear_at_end     <= 1'b0;
			mode3            <= 1'b0;
			seen_rise        <= 1'b0;
			write_latch_flag <= 1'b0;
			block_guard_low  <= 1'b0;
			block_guard_high <= 1'b0;
			pin_guard_enable <= 1'b0;
			buf_valid        <= 1'b0;
			buf_data         <= {`WBUF_W{1'b0}};
		end else if (CE) begin
			if (buf_valid & buf_ready)
				buf_valid <= 1'b0;
			if (cs_rise) begin
				state <= ST_IDLE;
				if (clear_at_end)
					write_latch_flag <= 1'b0;
				clear_at_end <= 1'b0;
			end else if (cs_fall) begin
				state        <= ST_OPCODE;
				mode3        <= sck_s;
				seen_rise    <= 1'b0;
				bit_cnt      <= `BIT_ZERO;
				addr_hi_done <= 1'b0;
				burst_stop   <= 1'b0;
				clear_at_end <= 1'b0;
			end else if (sck_rise) begin
				seen_rise <= 1'b1;
				bit_cnt   <= bit_cnt + `BIT_ONE;
				rx_shift  <= rx_byte[6:0];
				if (bit_cnt == `BIT_LAST) begin
					case (state)
					ST_OPCODE: begin
						case (rx_byte)
						`SET_WRITE_LATCH_CMD: begin
							write_latch_flag <= 1'b1;
							state            <= ST_IGNORE;
						end
						`CLEAR_WRITE_LATCH_CMD: begin
							clear_at_end <= 1'b1;
							state        <= ST_IGNORE;
						end
						`STATUS_READ_CMD: begin
							tx_shift <= status_byte(pin_guard_enable,
								block_guard_high, block_guard_low,
								write_latch_flag);
							state    <= ST_SREAD;
						end
						`STATUS_WRITE_CMD: begin
							clear_at_end <= 1'b1;
							state        <= ST_SWRITE;
						end
						`MEM_READ_CMD: begin
							is_read <= 1'b1;
							state   <= ST_ADDR;
						end
						`MEM_WRITE_CMD: begin
							is_read      <= 1'b0;
							clear_at_end <= 1'b1;
							state        <= ST_ADDR;
						end
						default: state <= ST_IGNORE;
						endcase
					end
					ST_ADDR: begin
						// Upper five address bits are dropped
						if (~addr_hi_done) begin
							addr[`ADDR_W-1:8] <= rx_byte[`ADDR_W-9:0];
							addr_hi_done      <= 1'b1;
						end else begin
							addr[7:0] <= rx_byte;
							if (is_read) begin
								tx_shift <= mem[{addr[`ADDR_W-1:8], rx_byte}];
								state    <= ST_RDATA;
							end else begin
								state <= ST_WDATA;
							end
						end
					end
					ST_WDATA: begin
						// Latch clear protects everything; pin is not consulted
						if (burst_stop | ~write_latch_flag |
							is_protected(block_guard_high, block_guard_low, addr)) begin
							burst_stop <= 1'b1;
						end else begin
							buf_valid <= 1'b1;
							buf_data  <= {addr, rx_byte};
							addr      <= addr_next;
						end
					end
					ST_RDATA: begin
						addr     <= addr_next;
						tx_shift <= mem[addr_next];
					end
					ST_SREAD: begin
						tx_shift <= status_byte(pin_guard_enable,
							block_guard_high, block_guard_low,
							write_latch_flag);
					end
					ST_SWRITE: begin
						if (write_latch_flag & ~(pin_guard_enable & ~guard_s)) begin
							pin_guard_enable <= rx_byte[`PIN_GUARD_BIT];
							block_guard_high <= rx_byte[`GUARD_HIGH_BIT];
							block_guard_low  <= rx_byte[`GUARD_LOW_BIT];
						end
						state <= ST_IGNORE;
					end
					default: state <= state;
					endcase
				end
			end else if (sck_fall & ((state == ST_RDATA) | (state == ST_SREAD))) begin
				tx_shift <= {tx_shift[6:0], 1'b0};
			end
		end
	end

	// Serial output: driven on falling edges only in read states
	always @(posedge SYS_CLK) begin
		if (RST) begin
			SO      <= 1'b0;
			SO_OE_N <= 1'b1;
			so_live <= 1'b0;
		end else if (CE) begin
			if (cs_s | (state == ST_IGNORE) | (state == ST_IDLE)) begin
				SO_OE_N <= 1'b1;
				so_live <= 1'b0;
			end else if (sck_fall & ((state == ST_RDATA) | (state == ST_SREAD))) begin
				SO      <= tx_shift[7];
				SO_OE_N <= 1'b0;
				so_live <= 1'b1;
			end else if (so_live & ~paused) begin
				// Resume must show the bit that stood before the pause
				SO_OE_N <= 1'b0;
			end
			if (paused)
				SO_OE_N <= 1'b1;
		end
	end

	// Array write port fed from the buffer
	always @(posedge SYS_CLK) begin
		if (CE & ~RST & drain_valid & drain_ready)
			mem[drain_data[`WBUF_W-1:8]] <= drain_data[7:0];
	end

	// Buffer hides read-port contention; bytes arrive far slower than it drains
	wbuf_fifo #(
		.WIDTH (`WBUF_W),
		.DEPTH (`WBUF_DEPTH),
		.AW    (`WBUF_AW)
	) u_wbuf (
		.clk       (SYS_CLK),
		.rst       (RST),
		.ce        (CE),
		.in_valid  (buf_valid),
		.in_ready  (buf_ready),
		.in_data   (buf_data),
		.out_valid (drain_valid),
		.out_ready (drain_ready),
		.out_data  (drain_data)
	);

endmodule
`default_nettype wire

// >>> verif/spi_fram_monitor.sv
// Pin checker for the serial memory command logic.
// Assumes bind to the top module and an SCK half period of 4 SYS_CLK.
`timescale 1ns/10ps
`default_nettype none
module spi_fram_monitor (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CS_N,
	input wire logic SCK,
	input wire logic HOLD_N,
	input wire logic SO,
	input wire logic SO_OE_N
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	chk_reset_release: assert property (
		$fell(RST) |-> SO_OE_N && !SO)
		else $error("output driven after reset");
	chk_release_cs: assert property (
		$rose(CS_N) |-> ##[1:5] SO_OE_N)
		else $error("output not released after select end");
	chk_idle_quiet: assert property (
		CS_N [*6] |-> SO_OE_N)
		else $error("output driven while deselected");
	chk_drive_selected: assert property (
		!SO_OE_N |-> !$past(CS_N, 5))
		else $error("output driven without select");
	// Settled delay of 2 to 4 cycles after a clock fall
	chk_so_on_fall: assert property (
		$changed(SO) && !SO_OE_N |-> $past(SCK, 5) && !$past(SCK, 2))
		else $error("output bit changed off a clock fall");
	// A resume from a pause also re-enables the output
	chk_enable_on_fall: assert property (
		$fell(SO_OE_N) |-> ($past(SCK, 5) && !$past(SCK, 2)) ||
			(HOLD_N && !$past(HOLD_N, 5) && !SCK))
		else $error("output enabled off a clock fall");
	chk_hold_release: assert property (
		(!HOLD_N && !SCK) [*5] |-> SO_OE_N)
		else $error("output driven while paused");
	chk_release_cause: assert property (
		$rose(SO_OE_N) |-> CS_N || !HOLD_N)
		else $error("output released without cause");
endmodule
bind spi_fram_command_logic spi_fram_monitor i_spi_fram_monitor (.SYS_CLK(SYS_CLK),
	.RST(RST), .CS_N(CS_N), .SCK(SCK), .HOLD_N(HOLD_N), .SO(SO), .SO_OE_N(SO_OE_N));
`default_nettype wire

// >>> verif/spi_master_model.sv
// SPI bus master model for the serial memory pins.
// Assumes calls just after a SYS_CLK edge; SCK period 8 cycles.
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
	input  wire logic SYS_CLK,
	input  wire logic SO,
	output var  logic CS_N,
	output var  logic SCK,
	output var  logic SI,
	output var  logic HOLD_N
);
	logic mode3 = 1'b0;
	initial begin
		CS_N = 1'b1;
		SCK = 1'b0;
		SI = 1'b0;
		HOLD_N = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask
	// Idle level at select picks the mode
	task automatic start(input logic m3);
		mode3 = m3;
		SCK <= m3;
		tick(4);
		CS_N <= 1'b0;
		tick(4);
	endtask
	// Clock stands still between frames; SI shows no stale bit
	task automatic stop;
		SCK <= mode3;
		tick(4);
		CS_N <= 1'b1;
		SI <= ~SI;
		tick(8);
	endtask
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			SCK <= 1'b0;
			SI <= tx[i];
			tick(4);
			SCK <= 1'b1;
			rx[i] = SO;
			tick(4);
		end
	endtask
	task automatic hold(input logic v);
		SCK <= 1'b0;
		tick(4);
		HOLD_N <= v;
		tick(4);
	endtask
endmodule
`default_nettype wire

// >>> verif/spi_fram_command_logic_tb.sv
// Self-checking bench for the serial memory command logic.
// Assumes the master model drives the serial pins; CE held high except during one frame.
`timescale 1ns/10ps
`default_nettype none
module spi_fram_command_logic_tb;
	logic        sys_clk;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        write_guard_n = 1'b1;
	logic        drove = 1'b0;
	wire         cs_n;
	wire         sck;
	wire         si;
	wire         hold_n;
	wire         so;
	wire         so_oe_n;
	wire         miso;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	logic [7:0]  prev = 8'h00;
	logic [7:0]  q [$];
	logic [7:0]  r [8];
	// Guard pin, status written, status read back
	logic [16:0] rows [5] = '{{1'b1, 8'hff, 8'h8c}, {1'b0, 8'h00, 8'h8c},
		{1'b1, 8'h04, 8'h04}, {1'b0, 8'h08, 8'h08}, {1'b1, 8'h00, 8'h00}};
	spi_fram_command_logic i_spi_fram_command_logic (.SYS_CLK(sys_clk), .RST(rst), .CE(ce),
		.CS_N(cs_n), .SCK(sck), .SI(si), .HOLD_N(hold_n), .WRITE_GUARD_N(write_guard_n),
		.SO(so), .SO_OE_N(so_oe_n));
	// Released line rests at its pull-up, so an undriven bit reads as one
	assign miso = so_oe_n ? 1'b1 : so;
	spi_master_model i_spi_master_model (.SYS_CLK(sys_clk), .SO(miso), .CS_N(cs_n), .SCK(sck),
		.SI(si), .HOLD_N(hold_n));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Run takes about 9630 cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (!so_oe_n) begin
			drove <= 1'b1;
		end
		if (cycles == 30000) begin
			err_count++;
			final_report;
		end
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// One select period; a pause is put before byte hp
	task automatic frame(input logic m3, input int hp);
		i_spi_master_model.start(m3);
		foreach (q[i]) begin
			if (i == hp) begin
				i_spi_master_model.hold(1'b0);
				i_spi_master_model.xbyte(8'hee, r[7]);
				i_spi_master_model.hold(1'b1);
			end
			i_spi_master_model.xbyte(q[i], r[i]);
		end
		i_spi_master_model.stop;
	endtask
	task automatic one(input logic [7:0] op);
		q = '{op};
		frame(1'b0, -1);
	endtask
	task automatic rs(input logic m3, input logic [7:0] exp);
		q = '{8'h05, 8'h00};
		frame(m3, -1);
		check("status", r[1], exp);
	endtask
	task automatic sw(input logic [7:0] v);
		one(8'h06);
		q = '{8'h01, v};
		frame(1'b0, -1);
	endtask
	task automatic mw(input logic [15:0] a, input logic [7:0] d0, d1, input int n, hp);
		one(8'h06);
		q = '{8'h02, a[15:8], a[7:0], d0};
		if (n > 1) begin
			q.push_back(d1);
		end
		frame(1'b0, hp);
	endtask
	task automatic mr(input logic [15:0] a, input logic [7:0] e0, e1, input int n);
		q = '{8'h03, a[15:8], a[7:0], 8'h00};
		if (n > 1) begin
			q.push_back(8'h00);
		end
		frame(1'b0, -1);
		check("read byte", r[3], e0);
		if (n > 1) begin
			check("next read byte", r[4], e1);
		end
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rs(1'b0, 8'h00);
		foreach (rows[i]) begin
			write_guard_n <= rows[i][16];
			one(8'h06);
			rs(1'b0, prev | 8'h02);
			q = '{8'h01, rows[i][15:8]};
			frame(1'b0, -1);
			rs(1'b0, rows[i][7:0]);
			prev = rows[i][7:0];
		end
		one(8'h06);
		one(8'h04);
		rs(1'b0, 8'h00);
		drove = 1'b0;
		q = '{8'hff, 8'h05, 8'h00};
		frame(1'b0, -1);
		check("driven on bad opcode", {7'h00, drove}, 8'h00);
		mw(16'h0020, 8'h5a, 8'h00, 1, 3);
		mr(16'h0020, 8'h5a, 8'h00, 1);
		mw(16'hffff, 8'h11, 8'h22, 2, -1);
		rs(1'b0, 8'h00);
		mr(16'hf7ff, 8'h11, 8'h22, 2);
		sw(8'h84);
		write_guard_n <= 1'b0;
		mw(16'h05ff, 8'h33, 8'h44, 2, -1);
		mw(16'h07ff, 8'h55, 8'h66, 2, -1);
		mr(16'h05ff, 8'h33, 8'h00, 1);
		mr(16'h07ff, 8'h11, 8'h22, 2);
		write_guard_n <= 1'b1;
		sw(8'h08);
		mw(16'h03ff, 8'h99, 8'haa, 2, -1);
		mr(16'h03ff, 8'h99, 8'h00, 1);
		sw(8'h0c);
		mw(16'h0000, 8'h77, 8'h00, 1, -1);
		mr(16'h0000, 8'h22, 8'h00, 1);
		rs(1'b1, 8'h0c);
		q = '{8'h03, 8'h00, 8'h20, 8'h00};
		frame(1'b0, 3);
		check("paused read byte", r[3], 8'h5a);
		ce <= 1'b0;
		one(8'h06);
		ce <= 1'b1;
		rs(1'b0, 8'h0c);
		rst <= 1'b1;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rs(1'b0, 8'h00);
		mr(16'h0020, 8'h5a, 8'h00, 1);
		final_report;
	end
endmodule
`default_nettype wire
